// File: pafs_pkg.sv
// constants, types and helpers for the port A pin-function select block
`default_nettype none
package pafs_pkg;

  // bus geometry
  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 32;
  localparam int REG_W      = 16;
  localparam int FIELD_W    = 3;
  localparam int NUM_FIELDS = 18;  // pins 0..15, then pin 28, pin 29

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_LOW1  = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_LOW2  = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_LOW3  = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_LOW4  = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_HIGH3 = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_HIGH4 = 12'h014;

  // writable bit masks, everything else is reserved and reads zero
  localparam logic [REG_W-1:0] WMASK_LOW   = 16'h7777;
  localparam logic [REG_W-1:0] WMASK_HIGH4 = 16'h0033;
  localparam logic [REG_W-1:0] WMASK_HIGH3 = 16'h0000;

  // values after reset
  localparam logic [REG_W-1:0] RST_ZERO         = 16'h0000;
  localparam logic [REG_W-1:0] RST_LOW4_EXT     = 16'h1000;
  localparam logic [REG_W-1:0] RST_LOW4_ROM_DIS = 16'h0111;
  localparam logic [REG_W-1:0] RST_LOW3_ROM_DIS = 16'h1100;

  // field positions
  localparam int FIELD_PITCH   = 4;
  localparam int HIGH4_P28_LSB = 0;
  localparam int HIGH4_P29_LSB = 4;
  localparam int PIN11_LSB     = 12;

  // codes
  localparam logic [FIELD_W-1:0] CODE_PORT  = 3'h0;
  localparam logic [FIELD_W-1:0] CODE_ALT1  = 3'h1;
  localparam logic [FIELD_W-1:0] CODE_ALT2  = 3'h2;
  localparam logic [FIELD_W-1:0] CODE_ALT3  = 3'h3;
  localparam logic [FIELD_W-1:0] CODE_ALT5  = 3'h5;
  localparam logic [FIELD_W-1:0] PIN11_LOCK = 3'h3;

  // legal codes per field, bit n set means code n is allowed; index = field
  localparam logic [NUM_FIELDS-1:0][7:0] PIN_LEGAL = {
    8'h0b, 8'h0b,                          // pin 29, pin 28
    8'h03, 8'h03, 8'h0b, 8'h0b,            // pins 15..12
    8'h0b, 8'h0b, 8'h2f, 8'h27,            // pins 11..8
    8'h07, 8'h07, 8'h2f, 8'h23,            // pins 7..4
    8'h23, 8'h2f, 8'h23, 8'h23};           // pins 3..0

  // codes that belong to the external bus side, dead in single-chip boot
  localparam logic [NUM_FIELDS-1:0][7:0] PIN_BUS = {
    8'h02, 8'h02,
    8'h02, 8'h02, 8'h02, 8'h02,
    8'h02, 8'h02, 8'h28, 8'h20,
    8'h04, 8'h04, 8'h20, 8'h20,
    8'h20, 8'h20, 8'h20, 8'h20};

  // boot strap encodings
  localparam logic [1:0] BOOT_SINGLE      = 2'h0;
  localparam logic [1:0] BOOT_EXT_ROM_EN  = 2'h1;
  localparam logic [1:0] BOOT_EXT_ROM_DIS = 2'h2;

  typedef enum logic [3:0] {
    ST_FILL1 = 4'h1,
    ST_FILL2 = 4'h2,
    ST_LOAD  = 4'h4,
    ST_RUN   = 4'h8
  } pafs_init_e;

  // byte-lane merge of a write into a 16-bit register
  function automatic logic [REG_W-1:0] reg_merge(input logic [REG_W-1:0] old_v,
                                                 input logic [REG_W-1:0] wdat,
                                                 input logic [1:0]       strb,
                                                 input logic [REG_W-1:0] wmask);
    logic [REG_W-1:0] lane;
    lane = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old_v & ~lane) | (wdat & lane);
  endfunction : reg_merge

  // 3-bit field in a given slot of a low register
  function automatic logic [FIELD_W-1:0] slot_field(input logic [REG_W-1:0] r,
                                                    input logic [1:0]       slot);
    return r[slot*FIELD_PITCH +: FIELD_W];
  endfunction : slot_field

endpackage : pafs_pkg
`default_nettype wire

// File: pafs_sel_if.sv
// carrier between a stored function field and its decoder
`timescale 1ns/10ps
`default_nettype none
interface pafs_sel_if;
  logic [2:0] code;
  logic [7:0] legal;
  logic [7:0] busmask;
  logic       single_chip;
  logic [2:0] eff;
  modport dec (input code, input legal, input busmask, input single_chip, output eff);
  modport ctl (output code, output legal, output busmask, output single_chip, input eff);
endinterface : pafs_sel_if
`default_nettype wire

// File: pafs_field_dec.sv
// decodes one stored field into the function that really reaches the pin
`timescale 1ns/10ps
`default_nettype none
module pafs_field_dec
(
  pafs_sel_if.dec sel
);
  // prohibited codes and bus codes in single-chip boot fall back to port
  always_comb
  begin
    if (sel.legal[sel.code] && !(sel.single_chip && sel.busmask[sel.code]))
      sel.eff = sel.code;
    else
      sel.eff = 3'h0;
  end
endmodule : pafs_field_dec
`default_nettype wire

// File: pafs_strap.sv
// strap synchroniser and post-reset load sequencer
`timescale 1ns/10ps
`default_nettype none
module pafs_strap
  import pafs_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic [1:0] boot_mode_i,
  output logic            init_load_o,
  output logic            init_done_o,
  output logic [1:0]      boot_mode_o
);
  logic [1:0] mode_s1_r;
  logic [1:0] mode_s2_r;
  pafs_init_e state_r;
  logic       load_r;
  logic       done_r;

  // two-flop synchroniser; the first stage feeds only the second
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mode_s1_r <= 2'h0;
      mode_s2_r <= 2'h0;
    end
    else
    begin
      mode_s1_r <= boot_mode_i;
      mode_s2_r <= mode_s1_r;
    end
  end

  // wait for the synchroniser to fill, load once, then run
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_r <= ST_FILL1;
    else
      case (state_r)
        ST_FILL1: state_r <= ST_FILL2;
        ST_FILL2: state_r <= ST_LOAD;
        ST_LOAD:  state_r <= ST_RUN;
        ST_RUN:   state_r <= ST_RUN;
        default:  state_r <= ST_FILL1;
      endcase
  end

  // strap is caught once; later pin wiggles have no effect
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      boot_mode_o <= BOOT_SINGLE;
    else if (state_r == ST_LOAD)
      boot_mode_o <= mode_s2_r;
  end

  // preset pulse rises on the edge that catches the strap, so presets land one edge later and see the new mode
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      load_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      load_r <= (state_r == ST_LOAD);
      done_r <= done_r | ((state_r == ST_RUN) && !load_r);
    end
  end

  // ready one edge after the presets land, so a waiting read reloads fresh data
  assign init_load_o = load_r;
  assign init_done_o = done_r;
endmodule : pafs_strap
`default_nettype wire

// File: pafs_top.sv
// port A pin-function select registers with APB slave and pin decoders
`timescale 1ns/10ps
`default_nettype none
module pafs_top
  import pafs_pkg::*;
(
  input  wire logic                                            ref_clk_i,
  input  wire logic                                            resetn_i,
  input  wire logic                                            psel_i,
  input  wire logic                                            penable_i,
  input  wire logic                                            pwrite_i,
  input  wire logic [pafs_pkg::ADDR_W-1:0]                     paddr_i,
  input  wire logic [pafs_pkg::DATA_W-1:0]                     pwdata_i,
  input  wire logic [3:0]                                      pstrb_i,
  output logic                                                 pready_o,
  output logic [pafs_pkg::DATA_W-1:0]                          prdata_o,
  output logic                                                 pslverr_o,
  input  wire logic [1:0]                                      boot_mode_i,
  output logic                                                 init_done_o,
  output logic [pafs_pkg::NUM_FIELDS-1:0][pafs_pkg::FIELD_W-1:0] pin_func_code_o,
  output logic [pafs_pkg::NUM_FIELDS-1:0]                      pin_is_port_o
);
  import pafs_pkg::*;

  logic [REG_W-1:0]                     porta_func_sel_low1_r;
  logic [REG_W-1:0]                     porta_func_sel_low2_r;
  logic [REG_W-1:0]                     porta_func_sel_low3_r;
  logic [REG_W-1:0]                     porta_func_sel_low4_r;
  logic [REG_W-1:0]                     porta_func_sel_high4_r;
  logic [REG_W-1:0]                     low3_nxt;
  logic                                 init_load;
  logic [1:0]                           boot_mode;
  logic                                 single_chip;
  logic                                 ext_boot;
  logic                                 rom_dis_boot;
  logic                                 setup_ph;
  logic                                 access_ph;
  logic                                 wr_en;
  logic                                 sel_low1;
  logic                                 sel_low2;
  logic                                 sel_low3;
  logic                                 sel_low4;
  logic                                 sel_high3;
  logic                                 sel_high4;
  logic                                 hit;
  logic [REG_W-1:0]                     rd_val;
  logic [REG_W-1:0]                     wdat16;
  logic [1:0]                           strb16;
  logic [NUM_FIELDS-1:0][FIELD_W-1:0]   fld_code;
  logic [NUM_FIELDS-1:0][FIELD_W-1:0]   eff_code;

  // boot strap capture and load timing
  pafs_strap u_strap
  (
    .ref_clk_i   (ref_clk_i),
    .resetn_i    (resetn_i),
    .boot_mode_i (boot_mode_i),
    .init_load_o (init_load),
    .init_done_o (init_done_o),
    .boot_mode_o (boot_mode)
  );

  // boot mode 3 is not defined, so it is treated like single-chip
  assign ext_boot     = (boot_mode == BOOT_EXT_ROM_EN) || (boot_mode == BOOT_EXT_ROM_DIS);
  assign rom_dis_boot = (boot_mode == BOOT_EXT_ROM_DIS);
  assign single_chip  = !ext_boot;

  // apb phases; no wait states once the boot load is done
  assign setup_ph  = psel_i && !penable_i;
  assign access_ph = psel_i && penable_i;
  assign pready_o  = init_done_o;
  assign wr_en     = access_ph && pwrite_i && pready_o;
  assign wdat16    = pwdata_i[REG_W-1:0];
  assign strb16    = pstrb_i[1:0];

  // address decode
  always_comb
  begin
    sel_low1  = 1'b0;
    sel_low2  = 1'b0;
    sel_low3  = 1'b0;
    sel_low4  = 1'b0;
    sel_high3 = 1'b0;
    sel_high4 = 1'b0;
    if (paddr_i == OFS_LOW1)
      sel_low1 = 1'b1;
    else if (paddr_i == OFS_LOW2)
      sel_low2 = 1'b1;
    else if (paddr_i == OFS_LOW3)
      sel_low3 = 1'b1;
    else if (paddr_i == OFS_LOW4)
      sel_low4 = 1'b1;
    else if (paddr_i == OFS_HIGH3)
      sel_high3 = 1'b1;
    else if (paddr_i == OFS_HIGH4)
      sel_high4 = 1'b1;
  end

  assign hit       = sel_low1 | sel_low2 | sel_low3 | sel_low4 | sel_high3 | sel_high4;
  assign pslverr_o = access_ph && !hit;

  // read mux; reserved bits never stored, so they read zero
  always_comb
  begin
    rd_val = RST_ZERO;
    if (sel_low1)
      rd_val = porta_func_sel_low1_r & WMASK_LOW;
    else if (sel_low2)
      rd_val = porta_func_sel_low2_r & WMASK_LOW;
    else if (sel_low3)
      rd_val = porta_func_sel_low3_r & WMASK_LOW;
    else if (sel_low4)
      rd_val = porta_func_sel_low4_r & WMASK_LOW;
    else if (sel_high4)
      rd_val = porta_func_sel_high4_r & WMASK_HIGH4;
    else if (sel_high3)
      rd_val = WMASK_HIGH3;  // pins 24..27 live outside this block
  end

  // read data loaded at setup and again on each waited access edge, so a read
  // that waits out the boot load returns the preset rather than a stale value
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      prdata_o <= 32'h0;
    else if (!pwrite_i && (setup_ph || (access_ph && !pready_o)))
      prdata_o <= {16'h0, rd_val};
  end

  // pins 3..0
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      porta_func_sel_low1_r <= RST_ZERO;
    else if (init_load)
      porta_func_sel_low1_r <= RST_ZERO;
    else if (wr_en && sel_low1)
      porta_func_sel_low1_r <= reg_merge(porta_func_sel_low1_r, wdat16, strb16, WMASK_LOW);
  end

  // pins 7..4
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      porta_func_sel_low2_r <= RST_ZERO;
    else if (init_load)
      porta_func_sel_low2_r <= RST_ZERO;
    else if (wr_en && sel_low2)
      porta_func_sel_low2_r <= reg_merge(porta_func_sel_low2_r, wdat16, strb16, WMASK_LOW);
  end

  // pins 11..8; the output-disable 5 choice is sticky until reset
  always_comb
  begin
    low3_nxt = reg_merge(porta_func_sel_low3_r, wdat16, strb16, WMASK_LOW);
    if (porta_func_sel_low3_r[PIN11_LSB +: FIELD_W] == PIN11_LOCK)
      low3_nxt[PIN11_LSB +: FIELD_W] = PIN11_LOCK;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      porta_func_sel_low3_r <= RST_ZERO;
    else if (init_load)
      porta_func_sel_low3_r <= rom_dis_boot ? RST_LOW3_ROM_DIS : RST_ZERO;
    else if (wr_en && sel_low3)
      porta_func_sel_low3_r <= low3_nxt;
  end

  // pins 15..12; lsb preset from the boot strap once the sync has settled
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      porta_func_sel_low4_r <= RST_ZERO;
    else if (init_load)
      porta_func_sel_low4_r <= (ext_boot ? RST_LOW4_EXT : RST_ZERO)
                             | (rom_dis_boot ? RST_LOW4_ROM_DIS : RST_ZERO);
    else if (wr_en && sel_low4)
      porta_func_sel_low4_r <= reg_merge(porta_func_sel_low4_r, wdat16, strb16, WMASK_LOW);
  end

  // pins 29 and 28
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      porta_func_sel_high4_r <= RST_ZERO;
    else if (init_load)
      porta_func_sel_high4_r <= RST_ZERO;
    else if (wr_en && sel_high4)
      porta_func_sel_high4_r <= reg_merge(porta_func_sel_high4_r, wdat16, strb16, WMASK_HIGH4);
  end

  // gather stored fields; 2-bit high fields zero-extend onto the same codes
  always_comb
  begin
    for (int s = 0; s < 4; s++)
    begin
      fld_code[s]      = slot_field(porta_func_sel_low1_r, 2'(s));
      fld_code[s + 4]  = slot_field(porta_func_sel_low2_r, 2'(s));
      fld_code[s + 8]  = slot_field(porta_func_sel_low3_r, 2'(s));
      fld_code[s + 12] = slot_field(porta_func_sel_low4_r, 2'(s));
    end
    fld_code[16] = {1'b0, porta_func_sel_high4_r[HIGH4_P28_LSB +: 2]};
    fld_code[17] = {1'b0, porta_func_sel_high4_r[HIGH4_P29_LSB +: 2]};
  end

  // one decoder per field, legal-code tables live in the package
  for (genvar g = 0; g < NUM_FIELDS; g++)
  begin : g_dec
    pafs_sel_if sel_if ();
    assign sel_if.code        = fld_code[g];
    assign sel_if.legal       = PIN_LEGAL[g];
    assign sel_if.busmask     = PIN_BUS[g];
    assign sel_if.single_chip = single_chip;
    assign eff_code[g]        = sel_if.eff;
    pafs_field_dec u_dec
    (
      .sel (sel_if.dec)
    );
  end

  // registered pin routing so the pad muxes see glitch-free selects
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pin_func_code_o <= '0;
      pin_is_port_o   <= '1;
    end
    else
    begin
      pin_func_code_o <= eff_code;
      for (int p = 0; p < NUM_FIELDS; p++)
        pin_is_port_o[p] <= (eff_code[p] == CODE_PORT);
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // a chosen legal code reaches the pin one cycle later
  property route_p(logic [2:0] fld, logic [2:0] code, logic [2:0] eff, logic gate);
    (init_done_o && gate && fld == code) |=> (eff == code);
  endproperty

  rsv_read_zero_a: assert property ((access_ph && !pwrite_i) |->
      ((prdata_o[31:16] == 16'h0) && ((prdata_o[15:0] & 16'h8888) == 16'h0)))
    else $error("reserved bits read nonzero");

  pin15_clk_a: assert property (
      route_p(fld_code[15], CODE_ALT1, pin_func_code_o[15], ext_boot))
    else $error("pin15 clock output not routed");

  pin14_rd_a: assert property (
      route_p(fld_code[14], CODE_ALT1, pin_func_code_o[14], ext_boot))
    else $error("pin14 read strobe not routed");

  pin13_od7_a: assert property (
      route_p(fld_code[13], CODE_ALT3, pin_func_code_o[13], 1'b1))
    else $error("pin13 output-disable 7 not routed");

  pin9_cke_a: assert property (
      route_p(fld_code[9], CODE_ALT5, pin_func_code_o[9], ext_boot))
    else $error("pin9 clock enable not routed");

  pin5_dreq_a: assert property (
      route_p(fld_code[5], CODE_ALT2, pin_func_code_o[5], 1'b1))
    else $error("pin5 dma request not routed");

  pin29_irq_a: assert property (
      route_p(fld_code[17], CODE_ALT3, pin_func_code_o[17], 1'b1))
    else $error("pin29 interrupt input not routed");

  // chip selects and bus strobes only route in an external boot
  pin10_cs0_a: assert property (
      route_p(fld_code[10], CODE_ALT1, pin_func_code_o[10], ext_boot))
    else $error("pin10 chip select 0 not routed");

  pin8_read_write_direction_a: assert property (
      route_p(fld_code[8], CODE_ALT5, pin_func_code_o[8], ext_boot))
    else $error("pin8 read/write direction not routed");

  pin7_cs3_a: assert property (
      route_p(fld_code[7], CODE_ALT2, pin_func_code_o[7], ext_boot))
    else $error("pin7 chip select 3 not routed");

  pin2_dreq_a: assert property (
      route_p(fld_code[2], CODE_ALT2, pin_func_code_o[2], 1'b1))
    else $error("pin2 dma request not routed");

  high3_zero_a: assert property ((access_ph && !pwrite_i && sel_high3) |->
      (prdata_o == 32'h0))
    else $error("pins 24..27 register read nonzero");

  // single-chip boot: the clock output code must leave pin 15 as a port
  single_clk_a: assert property ((single_chip && fld_code[15] == CODE_ALT1) |=>
      pin_is_port_o[15])
    else $error("clock output reached pin15 in single-chip boot");

  pin11_lock_a: assert property (
      (porta_func_sel_low3_r[14:12] == PIN11_LOCK) |=> (porta_func_sel_low3_r[14:12] == PIN11_LOCK))
    else $error("pin11 field left the locked code");

  boot_ext_a: assert property ($rose(init_done_o) && ext_boot |->
      porta_func_sel_low4_r[12] && (rom_dis_boot == porta_func_sel_low3_r[8]))
    else $error("boot preset of pin15 or pin10 wrong");

  boot_romdis_a: assert property ($rose(init_done_o) && rom_dis_boot |->
      ((porta_func_sel_low4_r & 16'h0111) == 16'h0111) && porta_func_sel_low3_r[12])
    else $error("rom-disabled boot presets missing");

  bad_code_port_a: assert property ((!PIN_LEGAL[7][fld_code[7]]) |=> pin_is_port_o[7])
    else $error("prohibited pin7 code left pin routed");

  single_bus_a: assert property ((single_chip && fld_code[0] == CODE_ALT5) |=>
      pin_is_port_o[0] ##1 pin_is_port_o[0] || fld_code[0] != CODE_ALT5)
    else $error("bus function reached pin0 in single-chip boot");

  wr_lock_c: cover property (wr_en && sel_low3 && porta_func_sel_low3_r[14:12] == PIN11_LOCK);
  rd_c:      cover property (access_ph && !pwrite_i && sel_low4 && pready_o);
  bad_c:     cover property (wr_en && sel_low2 && wdat16[14:12] == 3'h7);
  err_c:     cover property (pslverr_o && pready_o);
  boot_c:    cover property ($rose(init_done_o) && rom_dis_boot);

endmodule : pafs_top
`default_nettype wire

// File: pafs_periph_model.sv
// far-side model: which pins the peripherals have taken from the port
`timescale 1ns/10ps
`default_nettype none
module pafs_periph_model
  import pafs_pkg::*;
(
  input  wire logic                                               ref_clk_i,
  input  wire logic                                               resetn_i,
  input  wire logic [pafs_pkg::NUM_FIELDS-1:0][pafs_pkg::FIELD_W-1:0] pin_func_code_i,
  output logic [pafs_pkg::NUM_FIELDS-1:0]                         claimed_o
);
  // a peripheral owns a pin only while a nonzero code reaches it,
  // so a prohibited code must never hand a pin over
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      claimed_o <= '0;
    else
      for (int i = 0; i < NUM_FIELDS; i++)
        claimed_o[i] <= |pin_func_code_i[i];
  end
endmodule : pafs_periph_model
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the port A pin-function select block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pafs_pkg::*;
  typedef struct packed {
    logic [11:0] a;
    logic [15:0] w;
    logic [15:0] r;
    logic [4:0]  idx;
    logic [2:0]  c;
  } pafs_row_s;
  logic                                 ref_clk, resetn, psel, penable, pwrite;
  logic [ADDR_W-1:0]                    paddr;
  logic [DATA_W-1:0]                    pwdata, prdata, rd;
  logic [3:0]                           pstrb;
  logic                                 pready, pslverr, init_done, err;
  logic [1:0]                           boot;
  logic [NUM_FIELDS-1:0][FIELD_W-1:0]   code;
  logic [NUM_FIELDS-1:0]                is_port, claimed;
  int                                   n_mismatch, check_count;
  // ext-rom-enabled boot, so bus codes are live
  pafs_row_s rows [23] = '{
    '{12'h000, 16'hfd5d, 16'h7555, 5'd0, 3'h5},
    '{12'h000, 16'hfd5d, 16'h7555, 5'd1, 3'h5},
    '{12'h000, 16'h1230, 16'h1230, 5'd2, 3'h2},
    '{12'h000, 16'h1230, 16'h1230, 5'd1, 3'h0},
    '{12'h000, 16'h5000, 16'h5000, 5'd3, 3'h5},
    '{12'h004, 16'h2153, 16'h2153, 5'd5, 3'h5},
    '{12'h004, 16'h2153, 16'h2153, 5'd4, 3'h0},
    '{12'h004, 16'h2155, 16'h2155, 5'd4, 3'h5},
    '{12'h004, 16'h7155, 16'h7155, 5'd7, 3'h0},
    '{12'h004, 16'h2155, 16'h2155, 5'd6, 3'h1},
    '{12'h004, 16'h2155, 16'h2155, 5'd7, 3'h2},
    '{12'h008, 16'h0135, 16'h0135, 5'd9, 3'h3},
    '{12'h008, 16'h0135, 16'h0135, 5'd8, 3'h5},
    '{12'h008, 16'h0135, 16'h0135, 5'd10, 3'h1},
    '{12'h00c, 16'h1133, 16'h1133, 5'd13, 3'h3},
    '{12'h00c, 16'h1133, 16'h1133, 5'd12, 3'h3},
    '{12'h00c, 16'h1133, 16'h1133, 5'd15, 3'h1},
    '{12'h00c, 16'h1133, 16'h1133, 5'd14, 3'h1},
    '{12'h00c, 16'h2233, 16'h2233, 5'd14, 3'h0},
    '{12'h014, 16'hff13, 16'h0013, 5'd16, 3'h3},
    '{12'h014, 16'hff13, 16'h0013, 5'd17, 3'h1},
    '{12'h010, 16'hffff, 16'h0000, 5'd17, 3'h1},
    '{12'h008, 16'h3444, 16'h3444, 5'd11, 3'h3}};
  pafs_top dut (.ref_clk_i(ref_clk), .resetn_i(resetn), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .boot_mode_i(boot), .init_done_o(init_done), .pin_func_code_o(code),
    .pin_is_port_o(is_port));
  pafs_periph_model model (.ref_clk_i(ref_clk), .resetn_i(resetn),
    .pin_func_code_i(code), .claimed_o(claimed));
  // free-running 8 ns clock
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic test_done;
    $display("mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_rd
  task automatic chk_pin(input logic [2:0] got, input logic [2:0] exp);
    chk_rd({29'h0, got}, {29'h0, exp});
  endtask : chk_pin
  // one apb transfer; the request is held until pready is seen high, for at most 50 edges, then the test ends
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {16'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge ref_clk);
      if (pready === 1'b1)
        break;
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 50)
    begin
      n_mismatch++;
      test_done();
    end
  endtask : apb
  // reset held 12 cycles with the boot strap stable throughout
  task automatic do_reset(input logic [1:0] mode);
    @(posedge ref_clk);
    resetn <= 1'b0;
    boot   <= mode;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
  endtask : do_reset
  initial
  begin
    {n_mismatch, check_count} = 0;
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'h3;
    boot  = BOOT_EXT_ROM_EN;
    do_reset(BOOT_EXT_ROM_EN);
    apb(1'b0, OFS_LOW4, 16'h0);
    chk_rd(rd, 32'h1000);
    apb(1'b0, OFS_LOW3, 16'h0);
    chk_rd(rd, 32'h0);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 16'h0);
      chk_rd(rd, {16'h0, rows[i].r});
      chk_pin(code[rows[i].idx], rows[i].c);
    end
    // field locked on output-disable 5: the write must not change the pin 11 field
    apb(1'b1, OFS_LOW3, 16'h1000);
    apb(1'b0, OFS_LOW3, 16'h0);
    chk_rd(rd, 32'h3000);
    chk_pin(code[11], 3'h3);
    // unmapped place refuses and reads zero
    apb(1'b1, 12'h018, 16'hffff);
    chk_rd({31'h0, err}, 32'h1);
    apb(1'b0, 12'h018, 16'h0);
    chk_rd(rd, 32'h0);
    chk_rd({14'h0, claimed}, 32'h000338f8);
    chk_rd({14'h0, is_port}, 32'h0000c707);
    // second reset, rom disabled: bus strobes and chip selects preset
    do_reset(BOOT_EXT_ROM_DIS);
    apb(1'b0, OFS_LOW4, 16'h0);
    chk_rd(rd, 32'h1111);
    apb(1'b0, OFS_LOW3, 16'h0);
    chk_rd(rd, 32'h1100);
    chk_pin(code[14], 3'h1);
    // single-chip boot: no preset, bus codes stay dead at the pin
    do_reset(BOOT_SINGLE);
    apb(1'b0, OFS_LOW4, 16'h0);
    chk_rd(rd, 32'h0);
    apb(1'b1, OFS_LOW4, 16'h1031);
    apb(1'b0, OFS_LOW4, 16'h0);
    chk_rd(rd, 32'h1031);
    chk_pin(code[12], 3'h0);
    chk_pin(code[13], 3'h3);
    chk_pin(code[15], 3'h0);
    apb(1'b1, OFS_LOW1, 16'h0005);
    apb(1'b0, OFS_LOW1, 16'h0);
    chk_rd(rd, 32'h0005);
    chk_pin(code[0], 3'h0);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
